// ==== dv/hibernation_power_rtc_controller_test.sv ====
// Self-checking bench for the sleep power controller.
// Assumes the design package and a zero-wait APB slave on a 100 MHz clock.
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin failures++; \
   $display("CHECK FAILED at %0t: got %h exp %h", $time, g, e); end end
module hibernation_power_rtc_controller_test;
   timeunit 1ns;
   timeprecision 1ps;
   import sleep_pkg::*;
   localparam int PH = 4;
   localparam int WR_GAP = 4;
   localparam int LIMIT = 5000;
   localparam logic [11:0] RA [6] = '{OFS_CNT, OFS_MATCH_A, OFS_MATCH_B,
      OFS_LOAD, OFS_TRIM, OFS_MEM_HI};
   localparam logic [31:0] RV [6] = '{32'h0, MATCH_RST, MATCH_RST, LOAD_RST,
      32'h0000_7FFF, 32'h0};
   logic        clk, rst, psel, penable, pwrite, pready, pslverr, err;
   logic        xtal, osc, wake_n, low_batt, reg_n, por, irq, vdd_on;
   logic        wake_press, batt_low;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   int          failures, cmp_count, cyc;

   sleep_power_rtc_ctrl #(.POR_HOLD(PH)) dut_u (
      .clk_sys_in(clk), .sys_rst_in(rst), .psel_in(psel),
      .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
      .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
      .pslverr_out(pslverr), .xtal_clk_in(xtal), .osc_clk_in(osc),
      .wake_n_in(wake_n), .low_batt_in(low_batt),
      .regulator_off_n_out(reg_n), .main_por_out(por), .irq_out(irq));
   sleep_far_side far_u (
      .wake_press_in(wake_press), .batt_low_in(batt_low),
      .regulator_off_n_in(reg_n), .xtal_clk_out(xtal), .osc_clk_out(osc),
      .wake_n_out(wake_n), .low_batt_out(low_batt), .vdd_on_out(vdd_on));

   task automatic results();
      $display("failures=%0d comparisons=%0d", failures, cmp_count);
      if (failures == 0 && cmp_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // Leaves the request up so two reads can run back to back
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
   endtask
   task automatic rel(input int n);
      psel <= 1'b0;
      penable <= 1'b0;
      repeat (n) @(posedge clk);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
      rel(WR_GAP);
   endtask
   task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      rel(1);
      `CHK(rd, e)
   endtask
   task automatic wait_reg(input logic v, input int lim);
      int n;
      n = 0;
      while (reg_n !== v && n < lim) begin
         @(posedge clk);
         n++;
      end
      `CHK(reg_n, v)
   endtask

   task automatic t_reset();
      for (int i = 0; i < 6; i++) rd_chk(RA[i], RV[i]);
   endtask
   task automatic t_mem();
      wr(OFS_MEM_LO, 32'hA5A5_0001);
      wr(OFS_MEM_HI, 32'h5A5A_0002);
      wr(OFS_CNT, 32'h0000_1234);
      apb(1'b0, OFS_MEM_LO, 32'h0);
      `CHK(rd, 32'hA5A5_0001)
      apb(1'b0, OFS_MEM_HI, 32'h0);
      `CHK(rd, 32'h5A5A_0002)
      apb(1'b0, OFS_CNT, 32'h0);
      `CHK(rd, 32'h0)
      apb(1'b0, 12'h028, 32'h0);
      `CHK(err, 1'b1)
      rel(1);
   endtask
   task automatic t_match();
      wr(OFS_CTL, 32'h0000_0040);
      rel(8);
      wr(OFS_MATCH_A, 32'h10);
      wr(OFS_MATCH_B, 32'h20);
      wr(OFS_MASK, 32'h2);
      wr(OFS_LOAD, 32'h20);
      rd_chk(OFS_CNT, 32'h20);
      rd_chk(OFS_RAW, 32'h2);
      `CHK(irq, 1'b1)
      wr(OFS_LOAD, 32'h10);
      rd_chk(OFS_RAW, 32'h3);
      rd_chk(OFS_MIS, 32'h2);
      wr(OFS_CLR, 32'h3);
      rd_chk(OFS_RAW, 32'h0);
      `CHK(irq, 1'b0)
   endtask
   task automatic t_abort();
      batt_low <= 1'b1;
      wr(OFS_MASK, 32'h4);
      wr(OFS_CTL, 32'h0000_00F6);
      repeat (6) @(posedge clk);
      `CHK(reg_n, 1'b1)
      rd_chk(OFS_RAW, 32'h4);
      rd_chk(OFS_CTL, 32'h0000_00F4);
      `CHK(irq, 1'b1)
      batt_low <= 1'b0;
      wr(OFS_CTL, 32'h0000_0044);
      wr(OFS_CLR, 32'h4);
      rd_chk(OFS_RAW, 32'h0);
   endtask
   task automatic t_pin_sleep();
      wr(OFS_CTL, 32'h0000_0076);
      wait_reg(1'b0, 4);
      `CHK(vdd_on, 1'b0)
      `CHK(por, 1'b1)
      batt_low <= 1'b1;
      repeat (10) @(posedge clk);
      rd_chk(OFS_RAW, 32'h0);
      batt_low <= 1'b0;
      repeat (4) @(posedge clk);
      wake_press <= 1'b1;
      wait_reg(1'b1, 12);
      `CHK(vdd_on, 1'b1)
      `CHK(por, 1'b1)
      wake_press <= 1'b0;
      repeat (PH + 3) @(posedge clk);
      `CHK(por, 1'b0)
      rd_chk(OFS_RAW, 32'h8);
      rd_chk(OFS_CTL, 32'h0000_0074);
      wr(OFS_CLR, 32'hF);
   endtask
   task automatic t_match_wake();
      wr(OFS_CTL, 32'h0000_004E);
      wait_reg(1'b0, 4);
      wr(OFS_LOAD, 32'h10);
      wait_reg(1'b1, 4);
      rd_chk(OFS_RAW, 32'h1);
   endtask

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         failures++;
         results();
      end
   end
   initial begin
      failures = 0; cmp_count = 0; cyc = 0; rst = 1'b1;
      psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
      pwdata = 32'h0; wake_press = 1'b0; batt_low = 1'b0;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_mem();
      t_match();
      t_abort();
      t_pin_sleep();
      t_match_wake();
      results();
   end
endmodule

// ==== dv/sleep_far_side.sv ====
// Far side of the sleep controller: slow clocks, wake pin, battery, regulator.
// Assumes the bench commands wake presses and the battery level.
module sleep_far_side (
   // Commands from the bench, and regulator enable from the controller
   input  wire logic wake_press_in,
   input  wire logic batt_low_in,
   input  wire logic regulator_off_n_in,
   // Pins toward the controller, and main supply state toward the bench
   output logic      xtal_clk_out,
   output logic      osc_clk_out,
   output logic      wake_n_out,
   output logic      low_batt_out,
   output logic      vdd_on_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // Both sources run free, so either select setting has a reference
   initial begin
      xtal_clk_out = 1'b0;
      forever #119.209 xtal_clk_out = ~xtal_clk_out;
   end
   initial begin
      osc_clk_out = 1'b0;
      forever #15258.789 osc_clk_out = ~osc_clk_out;
   end
   // Weak pull-up holds the pin high when nobody presses
   assign wake_n_out   = wake_press_in ? 1'b0 : 1'b1;
   assign low_batt_out = batt_low_in;
   // Low enable removes the main supply
   assign vdd_on_out   = regulator_off_n_in;
endmodule

// ==== hw/sleep_power_rtc_ctrl.sv ====
// Sleep power controller: regulator switch, seconds counter, retained memory.
// Assumes an APB master on clk_sys_in; slow clocks and pins are asynchronous.
// Contract
// - Low regulator enable turns power off
// - Wake pin or match releases regulator
// - Back-to-back reads need no gap
// - Select 0 divides by 128, 1 direct
// - Slow clock runs only when enabled
// - Enabled detector flags battery below threshold
// - Low battery can raise an interrupt
// - Abort bit refuses sleep on low battery
// - No battery checks while sleeping
// - Predivider ticks 32-bit counter each second
// - Trim count used one second in 64
// - Larger trim slows, smaller trim speeds
// - Two match registers wake or interrupt
// - Counter advances only when enabled
// - Load write sets counter at any time
// - Sixty-four retained read-write words
// - Sleep request starts sleep after wake setup
// - Pin and match wake enables arm sources
// - Wake gives reset, raw status keeps cause
// - Enabled events ORed onto one line
// - Writing one to clear drops event
// - Clock select sits at control bit 2
// - Counter value register is read-only
module sleep_power_rtc_ctrl #(
   parameter int POR_HOLD = sleep_pkg::POR_HOLD_CYC
) (
   // Clock and reset
   input  wire logic                        clk_sys_in,
   input  wire logic                        sys_rst_in,
   // APB slave
   input  wire logic                        psel_in,
   input  wire logic                        penable_in,
   input  wire logic                        pwrite_in,
   input  wire logic [sleep_pkg::ADDR_W-1:0] paddr_in,
   input  wire logic [31:0]                 pwdata_in,
   output logic      [31:0]                 prdata_out,
   output logic                             pready_out,
   output logic                             pslverr_out,
   // Slow clock pins
   input  wire logic                        xtal_clk_in,
   input  wire logic                        osc_clk_in,
   // Wake and battery pins
   input  wire logic                        wake_n_in,
   input  wire logic                        low_batt_in,
   // Power and event outputs
   output logic                             regulator_off_n_out,
   output logic                             main_por_out,
   output logic                             irq_out
);
   import sleep_pkg::*;

   localparam int POR_W = $clog2(POR_HOLD + 1);

   typedef struct packed {
      logic [MEM_WORDS-1:0][31:0] mem;
      logic [31:0]                cnt;
      logic [31:0]                match_a;
      logic [31:0]                match_b;
      logic [31:0]                load;
      logic [TRIM_W-1:0]          trim;
      logic [TRIM_W-1:0]          pdiv;
      logic [CTL_W-1:0]           ctl;
      logic [EV_W-1:0]            mask;
      logic [EV_W-1:0]            raw;
      logic [N_ASYNC-1:0]         s1;
      logic [N_ASYNC-1:0]         s2;
      logic [N_ASYNC-1:0]         s3;
      logic [N_ASYNC-1:0]         lvl;
      logic [DIV_W-1:0]           div;
      logic [SEC_IDX_W-1:0]       sec_idx;
      power_state_e               pst;
      logic [POR_W-1:0]           por_cnt;
      logic                       reg_on;
      logic                       por;
      logic                       irq;
      logic [31:0]                rdata;
   } state_s;

   state_s q;
   state_s d;

   logic [N_ASYNC-1:0] lvl_nx;
   logic [N_ASYNC-1:0] rise;
   logic [N_ASYNC-1:0] fall;
   logic               wr_acc;
   logic               rd_setup;
   logic               load_wr;
   logic               ref_tick;
   logic               sec_tick;
   logic               upd;
   logic               lb_chk;
   logic               wake;
   logic [31:0]        cnt_nx;
   logic [EV_W-1:0]    ev_set;
   logic [EV_W-1:0]    clr;

   function automatic logic is_mem(input logic [ADDR_W-1:0] a);
      return (a >= OFS_MEM_LO) && (a <= OFS_MEM_HI) && (a[1:0] == 2'h0);
   endfunction

   function automatic logic [MIDX_W-1:0] mem_idx(
      input logic [ADDR_W-1:0] a);
      logic [ADDR_W-1:0] off;
      off = a - OFS_MEM_LO;
      return off[MIDX_W+1:2];
   endfunction

   function automatic logic mapped(input logic [ADDR_W-1:0] a);
      return is_mem(a) || (a <= OFS_TRIM && a[1:0] == 2'h0);
   endfunction

   // A pin change counts only once the second and third stages agree
   assign lvl_nx   = (q.s2 & q.s3) | (q.lvl & (q.s2 ^ q.s3));
   assign rise     = lvl_nx & ~q.lvl;
   assign fall     = ~lvl_nx & q.lvl;

   assign wr_acc   = psel_in & penable_in & pwrite_in;
   assign rd_setup = psel_in & ~penable_in & ~pwrite_in;
   assign load_wr  = wr_acc && (paddr_in == OFS_LOAD);

   // Crystal edges are divided down; oscillator edges pass straight through
   assign ref_tick = q.ctl[CTL_CLK_EN] & (q.ctl[CTL_CLK_SEL] ?
                     rise[IN_OSC] :
                     (rise[IN_XTAL] & (q.div == DIV_LAST)));
   assign sec_tick = ref_tick & q.ctl[CTL_CNT_EN]
                     & (q.pdiv == '0);
   assign upd      = sec_tick | load_wr;
   assign cnt_nx   = load_wr ? pwdata_in :
                     (sec_tick ? q.cnt + 32'h1 : q.cnt);
   // Detector is not looked at while the rest of the chip is off
   assign lb_chk   = q.ctl[CTL_LB_EN] & (q.pst == ST_AWAKE)
                     & q.lvl[IN_LB];

   always_comb begin
      ev_set = '0;
      ev_set[EV_MATCH_A]  = upd & (cnt_nx == q.match_a);
      ev_set[EV_MATCH_B]  = upd & (cnt_nx == q.match_b);
      ev_set[EV_LOW_BATT] = lb_chk;
      ev_set[EV_PIN_WAKE] = fall[IN_WAKE];
   end

   assign clr  = (wr_acc && paddr_in == OFS_CLR) ?
                 pwdata_in[EV_W-1:0] : '0;
   assign wake = (q.pst == ST_SLEEP) &
                 ((q.ctl[CTL_PIN_WEN] & ~q.lvl[IN_WAKE]) |
                  (q.ctl[CTL_MATCH_WEN] &
                   (ev_set[EV_MATCH_A] | ev_set[EV_MATCH_B])));

   always_comb begin
      d     = q;
      d.s1  = {low_batt_in, wake_n_in, osc_clk_in, xtal_clk_in};
      d.s2  = q.s1;
      d.s3  = q.s2;
      d.lvl = lvl_nx;

      if (!q.ctl[CTL_CLK_EN]) begin
         d.div = '0;
      end else if (rise[IN_XTAL]) begin
         d.div = q.div + 1'b1;
      end

      // Trimmed count stretches or shrinks one second in every 64
      if (ref_tick && q.ctl[CTL_CNT_EN]) begin
         if (q.pdiv == '0) begin
            d.pdiv    = (q.sec_idx == SEC_IDX_LAST) ?
                        q.trim : TRIM_NOMINAL;
            d.sec_idx = q.sec_idx + 1'b1;
         end else begin
            d.pdiv = q.pdiv - 1'b1;
         end
      end
      d.cnt = cnt_nx;

      if (wr_acc) begin
         unique case (paddr_in)
            OFS_MATCH_A: d.match_a = pwdata_in;
            OFS_MATCH_B: d.match_b = pwdata_in;
            OFS_LOAD:    d.load    = pwdata_in;
            OFS_CTL:     d.ctl     = pwdata_in[CTL_W-1:0];
            OFS_MASK:    d.mask    = pwdata_in[EV_W-1:0];
            OFS_TRIM:    d.trim    = pwdata_in[TRIM_W-1:0];
            default: begin
               if (is_mem(paddr_in)) begin
                  d.mem[mem_idx(paddr_in)] = pwdata_in;
               end
            end
         endcase
      end

      // A new event outranks a clear in the same cycle
      d.raw = (q.raw & ~clr) | ev_set;

      if (q.por_cnt != '0) begin
         d.por_cnt = q.por_cnt - 1'b1;
      end

      unique case (q.pst)
         ST_AWAKE: begin
            if (q.ctl[CTL_SLEEP_REQ]) begin
               if (q.ctl[CTL_ABORT] & lb_chk) begin
                  d.ctl[CTL_SLEEP_REQ] = 1'b0;
               end else begin
                  d.pst    = ST_SLEEP;
                  d.reg_on = 1'b0;
               end
            end
         end
         ST_SLEEP: begin
            if (wake) begin
               d.pst                = ST_AWAKE;
               d.reg_on             = 1'b1;
               d.ctl[CTL_SLEEP_REQ] = 1'b0;
               d.por_cnt            = POR_W'(POR_HOLD);
            end
         end
      endcase

      // Main system is held in reset while off and briefly after wake
      d.por = (d.pst == ST_SLEEP) | (d.por_cnt != '0);
      d.irq = |(d.raw & d.mask);

      if (rd_setup) begin
         unique case (paddr_in)
            OFS_CNT:     d.rdata = q.cnt;
            OFS_MATCH_A: d.rdata = q.match_a;
            OFS_MATCH_B: d.rdata = q.match_b;
            OFS_LOAD:    d.rdata = q.load;
            OFS_CTL:     d.rdata = {{(32-CTL_W){1'b0}}, q.ctl};
            OFS_MASK:    d.rdata = {{(32-EV_W){1'b0}}, q.mask};
            OFS_RAW:     d.rdata = {{(32-EV_W){1'b0}}, q.raw};
            OFS_MIS:     d.rdata = {{(32-EV_W){1'b0}}, q.raw & q.mask};
            OFS_TRIM:    d.rdata = {{(32-TRIM_W){1'b0}}, q.trim};
            default: begin
               d.rdata = is_mem(paddr_in) ?
                         q.mem[mem_idx(paddr_in)] : 32'h0;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         q         <= '0;
         q.match_a <= MATCH_RST;
         q.match_b <= MATCH_RST;
         q.load    <= LOAD_RST;
         q.trim    <= TRIM_NOMINAL;
         q.pdiv    <= TRIM_NOMINAL;
         q.reg_on  <= 1'b1;
      end else begin
         q <= d;
      end
   end

   // Zero-wait slave: read data was captured in the setup cycle
   assign pready_out          = 1'b1;
   assign pslverr_out         = psel_in & penable_in & ~mapped(paddr_in);
   assign prdata_out          = q.rdata;
   assign regulator_off_n_out = q.reg_on;
   assign main_por_out        = q.por;
   assign irq_out             = q.irq;

   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (sys_rst_in);

   AST_OFF_WHILE_SLEEP: assert property (
      (q.pst == ST_SLEEP) |-> !regulator_off_n_out)
      else $error("regulator on while sleeping");

   AST_PIN_WAKE: assert property (
      (q.pst == ST_SLEEP && q.ctl[CTL_PIN_WEN] && !q.lvl[IN_WAKE])
      |=> regulator_off_n_out && main_por_out)
      else $error("pin wake did not restore power");

   AST_READ_NO_WAIT: assert property (
      (psel_in && penable_in) |-> pready_out)
      else $error("access phase stalled");

   AST_CLK_GATED: assert property (
      !q.ctl[CTL_CLK_EN] |-> !ref_tick ##1 (q.div == '0))
      else $error("slow reference ran while disabled");

   AST_LOW_BATT_FLAG: assert property (
      (q.ctl[CTL_LB_EN] && q.pst == ST_AWAKE && q.lvl[IN_LB])
      |=> q.raw[EV_LOW_BATT])
      else $error("low battery not flagged");

   AST_ABORT: assert property (
      (q.pst == ST_AWAKE && q.ctl[CTL_SLEEP_REQ] && q.ctl[CTL_ABORT]
       && lb_chk) |=> q.pst == ST_AWAKE && regulator_off_n_out
       && !q.ctl[CTL_SLEEP_REQ])
      else $error("sleep entered despite low battery");

   AST_NO_CHECK_ASLEEP: assert property (
      $rose(q.raw[EV_LOW_BATT]) |-> $past(q.pst) == ST_AWAKE)
      else $error("battery checked while sleeping");

   AST_SECOND_STEP: assert property (
      (sec_tick && !load_wr) |=> q.cnt == $past(q.cnt) + 32'h1)
      else $error("counter did not advance by one");

   AST_LOAD: assert property (
      load_wr |=> q.cnt == $past(pwdata_in))
      else $error("load value not taken");

   AST_IRQ_OR: assert property (
      ##1 irq_out == |(q.raw & q.mask))
      else $error("interrupt line disagrees with events");

   AST_ENTER_SLEEP: assert property (
      (q.pst == ST_AWAKE && q.ctl[CTL_SLEEP_REQ] && !q.ctl[CTL_ABORT])
      |=> !regulator_off_n_out && main_por_out)
      else $error("sleep request did not remove power");

   AST_STAY_ON: assert property (
      (q.pst == ST_AWAKE && !q.ctl[CTL_SLEEP_REQ])
      |=> regulator_off_n_out)
      else $error("power removed without a sleep request");

   AST_MATCH_WAKE: assert property (
      (q.pst == ST_SLEEP && q.ctl[CTL_MATCH_WEN] && load_wr
       && pwdata_in == q.match_a) |=> regulator_off_n_out
       && q.raw[EV_MATCH_A])
      else $error("counter match did not wake");

   AST_CLEAR_EVENT: assert property (
      (wr_acc && paddr_in == OFS_CLR && pwdata_in[EV_PIN_WAKE]
       && !fall[IN_WAKE]) |=> !q.raw[EV_PIN_WAKE])
      else $error("wake event not cleared");

   AST_POR_ON_WAKE: assert property (
      $rose(regulator_off_n_out) |-> main_por_out)
      else $error("main reset missing after wake");

   AST_COUNT_RO: assert property (
      (wr_acc && paddr_in == OFS_CNT && !sec_tick)
      |=> q.cnt == $past(q.cnt))
      else $error("counter changed by a direct write");
endmodule

// ==== inc/sleep_pkg.sv ====
// Constants and types for the sleep power controller.
// Assumes a 100 MHz system clock and an APB register port.
package sleep_pkg;
   localparam int          ADDR_W      = 12;
   localparam logic [11:0] OFS_CNT     = 12'h000;
   localparam logic [11:0] OFS_MATCH_A = 12'h004;
   localparam logic [11:0] OFS_MATCH_B = 12'h008;
   localparam logic [11:0] OFS_LOAD    = 12'h00C;
   localparam logic [11:0] OFS_CTL     = 12'h010;
   localparam logic [11:0] OFS_MASK    = 12'h014;
   localparam logic [11:0] OFS_RAW     = 12'h018;
   localparam logic [11:0] OFS_MIS     = 12'h01C;
   localparam logic [11:0] OFS_CLR     = 12'h020;
   localparam logic [11:0] OFS_TRIM    = 12'h024;
   localparam logic [11:0] OFS_MEM_LO  = 12'h030;
   localparam logic [11:0] OFS_MEM_HI  = 12'h12C;
   localparam int          MEM_WORDS   = 64;
   localparam int          MIDX_W      = 6;

   // Control register fields
   localparam int CTL_W         = 8;
   localparam int CTL_CNT_EN    = 0;
   localparam int CTL_SLEEP_REQ = 1;
   localparam int CTL_CLK_SEL   = 2;
   localparam int CTL_MATCH_WEN = 3;
   localparam int CTL_PIN_WEN   = 4;
   localparam int CTL_LB_EN     = 5;
   localparam int CTL_CLK_EN    = 6;
   localparam int CTL_ABORT     = 7;

   // Event bits of raw, mask, masked and clear registers
   localparam int EV_W       = 4;
   localparam int EV_MATCH_A = 0;
   localparam int EV_MATCH_B = 1;
   localparam int EV_LOW_BATT = 2;
   localparam int EV_PIN_WAKE = 3;

   localparam logic [31:0] MATCH_RST    = 32'hFFFFFFFF;
   localparam logic [31:0] LOAD_RST     = 32'hFFFFFFFF;
   localparam int          TRIM_W       = 16;
   localparam logic [15:0] TRIM_NOMINAL = 16'h7FFF;
   localparam int          DIV_W        = 7;
   localparam logic [6:0]  DIV_LAST     = 7'h7F;
   localparam int          SEC_IDX_W    = 6;
   localparam logic [5:0]  SEC_IDX_LAST = 6'h3F;

   // Asynchronous input positions
   localparam int N_ASYNC = 4;
   localparam int IN_XTAL = 0;
   localparam int IN_OSC  = 1;
   localparam int IN_WAKE = 2;
   localparam int IN_LB   = 3;

   localparam int CLK_PERIOD_NS = 10;
   localparam int POR_HOLD_NS   = 1000;
   localparam int POR_HOLD_CYC  =
      (POR_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   typedef enum logic {ST_AWAKE, ST_SLEEP} power_state_e;
endpackage
